// File: logic/level_sync.sv
// Two-flop synchroniser for a bus of slow, independently changing levels
module level_sync
  import pcs_lane_status_pkg::*;
#(
  parameter int WIDTH = LOOP_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second; bits may settle in different cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: logic/pcs_rx_lane_status_flags.sv
// Receive lane lock, marker, parity and lane-mapping status with APB registers
// Overview of operation
// - Lanes 0 to 3 report physical lane
// - Lane map valid only while lane synced
// - Lane parity failure pulses one cycle
// - Synced flag: word lock plus marker seen
// - Synced flags mirrored in lock status register
// - Error level on header loss or no marker
// - Marker spacing mismatch pulses one cycle
// - Four marker errors in row pulse once
// - Malformed marker word pulses one cycle
module pcs_rx_lane_status_flags
  import pcs_lane_status_pkg::*;
#(
  parameter int NUM_LANES = LANES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire lane_rx_t             lane_rx [NUM_LANES],
  input  wire logic [LOOP_W-1:0]    transceiver_loopback_select,
  input  wire apb_req_t             apb_req,
  output apb_rsp_t                  apb_rsp,
  output logic [PHYS_W-1:0]         lane0_phys_map,
  output logic [PHYS_W-1:0]         lane1_phys_map,
  output logic [PHYS_W-1:0]         lane2_phys_map,
  output logic [PHYS_W-1:0]         lane3_phys_map,
  output logic [NUM_LANES-1:0]      lane_lock_valid_flags,
  output logic [NUM_LANES-1:0]      lane_sync_error,
  output logic [NUM_LANES-1:0]      marker_spacing_error,
  output logic [NUM_LANES-1:0]      marker_repeat_error,
  output logic                      marker_format_error,
  output logic [NUM_LANES-1:0]      lane_bip_error,
  output logic                      irq
);

  // Software-visible control and interrupt state
  logic [SPACING_W-1:0]  marker_spacing_setting;
  logic [IRQ_W-1:0]      irq_status;
  logic [IRQ_W-1:0]      irq_mask;
  logic [LOOP_W-1:0]     loopback_seen;
  logic [IRQ_W-1:0]      irq_events;

  // Per-lane tracking state
  logic [NUM_LANES-1:0]  marker_found;
  logic [NUM_LANES-1:0]  ever_marker;
  logic [NUM_LANES-1:0]  lost_by_header;
  logic [NUM_LANES-1:0]  format_hit;
  logic [NUM_LANES-1:0]  spacing_hit;
  logic [NUM_LANES-1:0]  repeat_hit;
  logic [NUM_LANES-1:0]  bip_hit;
  logic [PHYS_W-1:0]     phys_map [NUM_LANES];
  logic [NUM_LANES-1:0]  loss_event;

  // APB access decode
  logic                  setup_phase;
  logic                  wr_access;
  logic [31:0]           read_word;
  logic                  read_hit;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;

  // Byte offset to register hit, used by read and write paths
  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
    is_reg = (addr == ofs);
  endfunction

  // Well-formed marker word on a locked lane, used by tracking and flags
  function automatic logic is_good_marker(input lane_rx_t w);
    is_good_marker = w.word_valid & w.block_lock & w.marker_seen & w.marker_ok;
  endfunction

  // Loopback select changes at any time; only its settled value is shown
  level_sync #(
    .WIDTH    (LOOP_W)
  ) u_loop_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (transceiver_loopback_select),
    .sync_out (loopback_seen)
  );

  // Lane tracking, one copy per lane
  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane

    logic [SPACING_W-1:0] word_count;
    logic [BIP_W-1:0]     bip_acc;
    logic [2:0]           err_run;
    logic                 at_marker;
    logic                 bad_format;
    logic                 bad_spacing;
    logic                 missed_marker;
    logic                 marker_error;
    logic                 good_marker;

    // A marker word seen while the lane holds word lock
    assign at_marker     = lane_rx[g].word_valid & lane_rx[g].block_lock & lane_rx[g].marker_seen;
    assign bad_format    = at_marker & ~lane_rx[g].marker_ok;
    // Spacing only checkable once a previous marker fixed the phase
    assign bad_spacing   = at_marker & marker_found[g] & (word_count != marker_spacing_setting);
    assign missed_marker = lane_rx[g].word_valid & lane_rx[g].block_lock & ~lane_rx[g].marker_seen
                           & marker_found[g] & (word_count == marker_spacing_setting);
    assign marker_error  = bad_format | bad_spacing | missed_marker;
    assign good_marker   = is_good_marker(lane_rx[g]);

    // Marker found since lock; dropped whenever word lock goes
    always_ff @(posedge clk) begin
      if (rst) begin
        marker_found[g] <= 1'b0;
      end else if (!lane_rx[g].block_lock) begin
        marker_found[g] <= 1'b0;
      end else if (good_marker) begin
        marker_found[g] <= 1'b1;
      end
    end

    // Marker ever received; only reset forgets it
    always_ff @(posedge clk) begin
      if (rst) begin
        ever_marker[g] <= 1'b0;
      end else if (good_marker) begin
        ever_marker[g] <= 1'b1;
      end
    end

    // Loss caused by header errors holds until the lane is synced again
    always_ff @(posedge clk) begin
      if (rst) begin
        lost_by_header[g] <= 1'b0;
      end else if (lane_rx[g].hdr_loss) begin
        lost_by_header[g] <= 1'b1;
      end else if (lane_lock_valid_flags[g]) begin
        lost_by_header[g] <= 1'b0;
      end
    end

    // Words since the last marker; restarts on a marker or a missed one
    always_ff @(posedge clk) begin
      if (rst) begin
        word_count <= '0;
      end else if (!lane_rx[g].block_lock) begin
        word_count <= '0;
      end else if (at_marker || missed_marker) begin
        word_count <= '0;
      end else if (lane_rx[g].word_valid) begin
        word_count <= word_count + 1'b1;
      end
    end

    // Consecutive marker error run; a clean marker ends the run
    always_ff @(posedge clk) begin
      if (rst) begin
        err_run <= '0;
      end else if (!lane_rx[g].block_lock) begin
        err_run <= '0;
      end else if (marker_error) begin
        err_run <= (err_run == REPEAT_LIMIT - 3'h1) ? 3'h0 : err_run + 3'h1;
      end else if (at_marker) begin
        err_run <= '0;
      end
    end

    // Running interleaved parity; the marker word starts the next span
    always_ff @(posedge clk) begin
      if (rst) begin
        bip_acc <= '0;
      end else if (at_marker) begin
        bip_acc <= lane_rx[g].word_bip;
      end else if (lane_rx[g].word_valid) begin
        bip_acc <= bip_acc ^ lane_rx[g].word_bip;
      end
    end

    // Physical lane captured from each well-formed marker
    always_ff @(posedge clk) begin
      if (rst) begin
        phys_map[g] <= '0;
      end else if (good_marker) begin
        phys_map[g] <= lane_rx[g].phys_lane;
      end
    end

    // Spacing pulse on a misplaced or a missing marker, one cycle per event
    always_ff @(posedge clk) begin
      if (rst) begin
        spacing_hit[g] <= 1'b0;
      end else begin
        spacing_hit[g] <= bad_spacing | missed_marker;
      end
    end

    // Repeat pulse on the error that completes a run
    always_ff @(posedge clk) begin
      if (rst) begin
        repeat_hit[g] <= 1'b0;
      end else begin
        repeat_hit[g] <= marker_error && (err_run == REPEAT_LIMIT - 3'h1);
      end
    end

    // Format pulse; lanes merge at the output with no extra stage
    always_ff @(posedge clk) begin
      if (rst) begin
        format_hit[g] <= 1'b0;
      end else begin
        format_hit[g] <= bad_format;
      end
    end

    // Parity only meaningful across a full span between good markers
    always_ff @(posedge clk) begin
      if (rst) begin
        bip_hit[g] <= 1'b0;
      end else begin
        bip_hit[g] <= good_marker & marker_found[g] & (bip_acc != lane_rx[g].marker_bip);
      end
    end

    // Header loss event, kept only for the interrupt status
    always_ff @(posedge clk) begin
      if (rst) begin
        loss_event[g] <= 1'b0;
      end else begin
        loss_event[g] <= lane_rx[g].hdr_loss;
      end
    end

  end

  // Lane level flags
  always_ff @(posedge clk) begin
    if (rst) begin
      lane_lock_valid_flags <= '0;
      lane_sync_error       <= '1;
    end else begin
      for (int i = 0; i < NUM_LANES; i++) begin
        // Flag may rise with the first good marker itself
        lane_lock_valid_flags[i] <= lane_rx[i].block_lock
                                    & (marker_found[i] | is_good_marker(lane_rx[i]));
        // Never cleared while no marker has ever come in
        lane_sync_error[i]       <= lost_by_header[i] | lane_rx[i].hdr_loss | ~ever_marker[i];
      end
    end
  end

  // Event outputs straight from the per-lane pulse flops
  assign marker_spacing_error = spacing_hit;
  assign marker_repeat_error  = repeat_hit;
  assign lane_bip_error       = bip_hit;
  // Format errors from any lane share the one output, same latency as the rest
  assign marker_format_error  = |format_hit;

  // Lane map outputs read as zero from one cycle after the lane's synced flag goes low
  always_ff @(posedge clk) begin
    if (rst) begin
      lane0_phys_map <= '0;
      lane1_phys_map <= '0;
      lane2_phys_map <= '0;
      lane3_phys_map <= '0;
    end else begin
      lane0_phys_map <= lane_lock_valid_flags[0] ? phys_map[0] : '0;
      lane1_phys_map <= lane_lock_valid_flags[1] ? phys_map[1] : '0;
      lane2_phys_map <= lane_lock_valid_flags[2] ? phys_map[2] : '0;
      lane3_phys_map <= lane_lock_valid_flags[3] ? phys_map[3] : '0;
    end
  end

  // APB phase decode; no wait states so access completes at once
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign wr_access   = apb_req.psel & apb_req.penable & apb_req.pwrite;

  // Spacing setting written by software, steers the spacing check
  always_ff @(posedge clk) begin
    if (rst) begin
      marker_spacing_setting <= SPACING_RST;
    end else if (wr_access && is_reg(apb_req.paddr, OFS_SPACING)) begin
      marker_spacing_setting <= apb_req.pwdata[SPACING_W-1:0];
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask <= IRQ_MASK_RST[IRQ_W-1:0];
    end else if (wr_access && is_reg(apb_req.paddr, OFS_IRQ_MASK)) begin
      irq_mask <= apb_req.pwdata[IRQ_W-1:0];
    end
  end

  // Event vector in status layout: format, loss, parity, repeat, spacing
  assign irq_events = {format_hit != '0, loss_event, bip_hit, repeat_hit, spacing_hit};

  // Sticky status; a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~((wr_access && is_reg(apb_req.paddr, OFS_IRQ_STAT))
                                    ? apb_req.pwdata[IRQ_W-1:0] : '0))
                    | irq_events;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // Read mux; reserved bits and unmapped offsets read as zero
  always_comb begin
    read_word = '0;
    read_hit  = 1'b1;
    if (is_reg(apb_req.paddr, OFS_SPACING)) begin
      read_word[SPACING_W-1:0] = marker_spacing_setting;
    end else if (is_reg(apb_req.paddr, OFS_LOCK)) begin
      read_word[NUM_LANES-1:0] = lane_lock_valid_flags;
    end else if (is_reg(apb_req.paddr, OFS_LANE)) begin
      read_word[LANE_ERR_POS +: NUM_LANES] = lane_sync_error;
      read_word[LANE_MAP_POS +: 8] = {lane3_phys_map, lane2_phys_map, lane1_phys_map, lane0_phys_map};
    end else if (is_reg(apb_req.paddr, OFS_IRQ_STAT)) begin
      read_word[IRQ_W-1:0] = irq_status;
    end else if (is_reg(apb_req.paddr, OFS_IRQ_MASK)) begin
      read_word[IRQ_W-1:0] = irq_mask;
    end else if (is_reg(apb_req.paddr, OFS_LOOPBACK)) begin
      read_word[LOOP_W-1:0] = loopback_seen;
    end else begin
      read_hit = 1'b0;
    end
  end

  // Read data and error captured in setup so the access phase sees flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : read_word;
      pslverr_q <= ~read_hit;
    end
  end

  // Ready in every access phase; data and error from the capture flops
  assign apb_rsp = '{pready: apb_req.psel & apb_req.penable, pslverr: pslverr_q, prdata: prdata_q};

endmodule

// File: shared/pcs_lane_status_pkg.sv
// Shared constants, register map and carrier types for the lane status block
package pcs_lane_status_pkg;

  // Lane geometry
  localparam int LANES     = 4;
  localparam int PHYS_W    = 2;
  localparam int SPACING_W = 16;
  localparam int BIP_W     = 8;
  localparam int LOOP_W    = 12;

  // Register byte offsets
  localparam logic [7:0] OFS_SPACING   = 8'h00;
  localparam logic [7:0] OFS_LOCK      = 8'h04;
  localparam logic [7:0] OFS_LANE      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_LOOPBACK  = 8'h14;

  // Values after reset
  localparam logic [SPACING_W-1:0] SPACING_RST  = 16'h3FFF;
  localparam logic [31:0]          IRQ_MASK_RST = 32'h0000_0000;

  // Marker error run length that raises a repeat error
  localparam logic [2:0] REPEAT_LIMIT = 3'h4;

  // Interrupt status field positions, one nibble per per-lane event kind, one bit for format
  localparam int IRQ_SPACING_POS = 0;
  localparam int IRQ_REPEAT_POS  = 4;
  localparam int IRQ_BIP_POS     = 8;
  localparam int IRQ_LOSS_POS    = 12;
  localparam int IRQ_FORMAT_POS  = 16;
  localparam int IRQ_W           = 17;

  // Lane status register field positions
  localparam int LANE_ERR_POS = 0;
  localparam int LANE_MAP_POS = 8;

  // Per-lane receive word information from the block-lock front end
  typedef struct packed {
    logic              word_valid;
    logic              block_lock;
    logic              hdr_loss;
    logic              marker_seen;
    logic              marker_ok;
    logic [PHYS_W-1:0] phys_lane;
    logic [BIP_W-1:0]  word_bip;
    logic [BIP_W-1:0]  marker_bip;
  } lane_rx_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// File: testbench/lane_source.sv
// Behavioural four-lane receive front end feeding the status block
module lane_source
  import pcs_lane_status_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [SPACING_W-1:0] spacing,
  input  wire logic [LANES-1:0]     lock,
  input  wire logic [1:0]           fault,
  input  wire logic [1:0]           fault_lane,
  input  wire logic                 loss,
  output lane_rx_t                  lane_rx [LANES]
);
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [SPACING_W-1:0] cnt;
    logic [BIP_W-1:0]     acc;
    logic [BIP_W-1:0]     wb;
    logic                 hit;
    logic                 mark;
    lane_rx_t             r;
    assign lane_rx[g] = r;
    assign hit = fault_lane == 2'(g);
    assign wb = 8'h5A ^ cnt[7:0];
    // On schedule, or early when a spacing fault is asked for
    assign mark = cnt == '0 || (hit && fault == 2'h3 && cnt == 16'h0002);
    // Lock loss restarts the count; idle lines go low except hdr_loss, which follows loss on the fault lane
    always_ff @(posedge clk) begin
      if (rst || !lock[g]) begin
        cnt <= '0;
        acc <= '0;
        r <= '{hdr_loss: loss && hit, default: '0};
      end else begin
        cnt <= mark ? 16'h0001 : (cnt == spacing ? '0 : cnt + 16'h0001);
        acc <= mark ? wb : acc ^ wb;
        r.word_valid <= 1'b1;
        r.block_lock <= 1'b1;
        r.hdr_loss <= 1'b0;
        r.marker_seen <= mark;
        r.marker_ok <= !(mark && hit && fault == 2'h1);
        r.phys_lane <= 2'(3 - g);
        r.word_bip <= wb;
        // Non-marker words carry a changing filler
        r.marker_bip <= mark ? acc ^ {7'h00, hit && fault == 2'h2} : ~acc;
      end
    end
  end
endmodule

// File: testbench/lane_status_properties.sv
// Port assertions for the receive lane status block
module lane_status_properties
  import pcs_lane_status_pkg::*;
#(
  parameter int NUM_LANES = LANES
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire lane_rx_t             lane_rx [NUM_LANES],
  input wire apb_req_t             apb_req,
  input wire logic [31:0]          prdata,
  input wire logic [PHYS_W-1:0]    lane2_phys_map,
  input wire logic [NUM_LANES-1:0] lane_lock_valid_flags,
  input wire logic [NUM_LANES-1:0] lane_sync_error,
  input wire logic [NUM_LANES-1:0] marker_spacing_error,
  input wire logic [NUM_LANES-1:0] marker_repeat_error,
  input wire logic                 marker_format_error,
  input wire logic [NUM_LANES-1:0] lane_bip_error
);
  logic bad_mark;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Malformed marker on any locked lane
  always_comb begin
    bad_mark = 1'b0;
    for (int i = 0; i < NUM_LANES; i++) begin
      bad_mark |= lane_rx[i].word_valid & lane_rx[i].block_lock & lane_rx[i].marker_seen & ~lane_rx[i].marker_ok;
    end
  end
  sequence s_good2;
    lane_rx[2].word_valid && lane_rx[2].block_lock && lane_rx[2].marker_seen && lane_rx[2].marker_ok;
  endsequence
  property p_map2;
    s_good2 ##2 lane_lock_valid_flags[2] |-> lane2_phys_map == $past(lane_rx[2].phys_lane, 2);
  endproperty
  // Map lags the flag by one stage, so gate on two idle cycles
  property p_gate;
    !lane_lock_valid_flags[2] && !$past(lane_lock_valid_flags[2]) |-> lane2_phys_map == 2'h0;
  endproperty
  property p_bip_once;
    lane_bip_error[0] |=> !lane_bip_error[0];
  endproperty
  property p_bip_lane;
    lane_bip_error[1] |-> $past(lane_rx[1].marker_seen && lane_rx[1].marker_ok);
  endproperty
  property p_lock;
    lane_lock_valid_flags[0] |-> $past(lane_rx[0].block_lock);
  endproperty
  property p_mirror;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == OFS_LOCK
      |=> prdata == 32'($past(lane_lock_valid_flags));
  endproperty
  property p_loss;
    lane_rx[2].hdr_loss |=> lane_sync_error[2];
  endproperty
  property p_spacing;
    marker_spacing_error[1] |-> $past(lane_rx[1].block_lock) ##1 !marker_spacing_error[1];
  endproperty
  property p_repeat;
    marker_repeat_error[1] |-> marker_spacing_error[1] || marker_format_error;
  endproperty
  property p_format;
    bad_mark |=> marker_format_error;
  endproperty
  a_map2: assert property (p_map2) else $error("map2 wrong");
  a_gate: assert property (p_gate) else $error("map2 ungated");
  a_bip_once: assert property (p_bip_once) else $error("bip0 long");
  a_bip_lane: assert property (p_bip_lane) else $error("bip1 cause");
  a_lock: assert property (p_lock) else $error("lock0 flag");
  a_mirror: assert property (p_mirror) else $error("lock reg");
  a_loss: assert property (p_loss) else $error("sync err2");
  a_spacing: assert property (p_spacing) else $error("spacing1");
  a_repeat: assert property (p_repeat) else $error("repeat1");
  a_format: assert property (p_format) else $error("format");
endmodule

bind pcs_rx_lane_status_flags lane_status_properties #(.NUM_LANES(NUM_LANES)) u_props (
  .clk(clk), .rst(rst), .lane_rx(lane_rx), .apb_req(apb_req), .prdata(apb_rsp.prdata),
  .lane2_phys_map(lane2_phys_map), .lane_lock_valid_flags(lane_lock_valid_flags),
  .lane_sync_error(lane_sync_error), .marker_spacing_error(marker_spacing_error),
  .marker_repeat_error(marker_repeat_error), .marker_format_error(marker_format_error),
  .lane_bip_error(lane_bip_error));

// File: testbench/pcs_rx_lane_status_flags_test.sv
// Self-checking bench for the receive lane status block
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pcs_rx_lane_status_flags_test
  import pcs_lane_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst;
  logic              loss;
  logic              fmt_err;
  logic              irq;
  logic              err;
  logic [1:0]        fault;
  logic [1:0]        fault_lane;
  logic [1:0]        map0, map1, map2, map3;
  logic [3:0]        lock;
  logic [3:0]        flags, sync_err, sp_err, rep_err, bip_err;
  logic [LOOP_W-1:0] loop_sel;
  logic [31:0]       rd;
  lane_rx_t          lane_rx [LANES];
  apb_req_t          apb_req;
  apb_rsp_t          apb_rsp;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                n_fmt = 0;
  int                n_sp [4];
  int                n_rep [4];
  int                n_bip [4];

  lane_source src (.clk(clk), .rst(rst), .spacing(16'h0003), .lock(lock), .fault(fault),
    .fault_lane(fault_lane), .loss(loss), .lane_rx(lane_rx));
  pcs_rx_lane_status_flags DUT (.clk(clk), .rst(rst), .lane_rx(lane_rx), .transceiver_loopback_select(loop_sel),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .lane0_phys_map(map0), .lane1_phys_map(map1),
    .lane2_phys_map(map2), .lane3_phys_map(map3), .lane_lock_valid_flags(flags), .lane_sync_error(sync_err),
    .marker_spacing_error(sp_err), .marker_repeat_error(rep_err), .marker_format_error(fmt_err),
    .lane_bip_error(bip_err), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse tallies on the falling edge, clear of rising-edge updates
  always @(negedge clk) begin
    cycles++;
    n_fmt += int'(fmt_err === 1'b1);
    for (int i = 0; i < 4; i++) begin
      n_sp[i] += int'(sp_err[i] === 1'b1);
      n_rep[i] += int'(rep_err[i] === 1'b1);
      n_bip[i] += int'(bip_err[i] === 1'b1);
    end
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out;
    $display("Checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Setup then access; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    `CHK("sync_err", 4'hF, sync_err)
    `CHK("flags", 4'h0, flags)
    apb(1'b0, OFS_SPACING, '0);
    `CHK("spacing", {16'h0, SPACING_RST}, rd)
    apb(1'b0, 8'h3C, '0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, OFS_SPACING, 32'h0000_0003);
    apb(1'b0, OFS_LOOPBACK, '0);
    `CHK("loopback", {20'h0, loop_sel}, rd)
  endtask
  task automatic t_sync;
    lock <= 4'hF;
    tick(16);
    `CHK("flags", 4'hF, flags)
    `CHK("sync_err", 4'h0, sync_err)
    `CHK("maps", 8'h1B, {map3, map2, map1, map0})
    apb(1'b0, OFS_LOCK, '0);
    `CHK("lock_reg", 32'h0000_000F, rd)
    apb(1'b0, OFS_LANE, '0);
    `CHK("lane_reg", 32'h0000_1B00, rd)
  endtask
  // Bad marker word, then bad parity, on each lane in turn
  task automatic t_faults;
    int f0;
    int b0 [4];
    for (int l = 0; l < 4; l++) begin
      fault_lane <= 2'(l);
      f0 = n_fmt;
      fault <= 2'h1;
      tick(4);
      fault <= 2'h0;
      tick(8);
      `CHK("fmt", f0 + 1, n_fmt)
      b0 = n_bip;
      fault <= 2'h2;
      tick(4);
      fault <= 2'h0;
      tick(8);
      for (int i = 0; i < 4; i++) `CHK("bip", b0[i] + int'(i == l), n_bip[i])
    end
  endtask
  // Run of early markers on lane 1, then the interrupt path
  task automatic t_repeat;
    int s0, r0, k;
    s0 = n_sp[1];
    r0 = n_rep[1];
    fault_lane <= 2'h1;
    fault <= 2'h3;
    k = 0;
    while (k < 5) begin
      @(posedge clk);
      k += int'(lane_rx[1].marker_seen === 1'b1);
    end
    fault <= 2'h0;
    tick(12);
    `CHK("repeat", r0 + 1, n_rep[1])
    `CHK("spacing_err", 1'b1, n_sp[1] - s0 >= 4)
    apb(1'b0, OFS_IRQ_STAT, '0);
    `CHK("stat", 2'b11, {rd[IRQ_REPEAT_POS + 1], rd[IRQ_SPACING_POS + 1]})
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, OFS_IRQ_MASK, 32'h0001_FFFF);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFS_IRQ_STAT, 32'h0001_FFFF);
    apb(1'b0, OFS_IRQ_STAT, '0);
    `CHK("stat_clr", 32'h0, rd)
    `CHK("irq_clr", 1'b0, irq)
  endtask
  task automatic t_loss;
    lock[2] <= 1'b0;
    loss <= 1'b1;
    fault_lane <= 2'h2;
    @(posedge clk);
    loss <= 1'b0;
    tick(3);
    `CHK("loss", 4'b1000, {sync_err[2], flags[2], map2})
    lock[2] <= 1'b1;
    tick(12);
    `CHK("relock", 4'b0101, {sync_err[2], flags[2], map2})
  endtask

  initial begin
    rst = 1'b1;
    lock = 4'h0;
    fault = 2'h0;
    fault_lane = 2'h0;
    loss = 1'b0;
    loop_sel = 12'hA5C;
    apb_req = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sync();
    t_faults();
    t_repeat();
    t_loss();
    close_out();
  end
endmodule
